/* verilog/pias_bank.sv */
/*
  interrupt status and auxiliary control/status bank of one phy port, apb slave.
  assumes all phy core status inputs and event pulses are on pclk; no sync needed.
  zero wait state apb; unmapped addresses answer with pslverr.
*/
// The implementer's own choice: the APB slave port.
`timescale 1ns/10ps
module pias_bank #(
  parameter int unsigned TO0_CYC = pias_pkg::TO0_CYC,
  parameter int unsigned TO1_CYC = pias_pkg::TO1_CYC,
  parameter int unsigned TO2_CYC = pias_pkg::TO2_CYC,
  parameter int unsigned TO3_CYC = pias_pkg::TO3_CYC
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic link_up,
  input wire logic [1:0] speed,
  input wire logic full_duplex_flag,
  input wire logic an_complete,
  input wire logic an_error_evt,
  input wire logic an_done_evt,
  input wire logic poe_detect_evt,
  input wire logic symbol_err_evt,
  input wire logic fast_fail_evt,
  input wire logic ext_int_evt,
  input wire logic media_change_evt,
  input wire logic false_carrier_evt,
  input wire logic downshift_evt,
  input wire logic ms_error_evt,
  input wire logic rx_er_evt,
  input wire logic rx_er_carrier_ext,
  input wire logic auto_pair_crossover,
  input wire logic cd_pair_swap,
  input wire logic [3:0] pair_polarity,
  input wire logic [1:0] media_sel,
  output logic phy_interrupt_pin_out,
  output logic phy_interrupt_pin_oe_n,
  output logic link_power_saving_sleep
);

  pias_pkg::pias_state_t st;
  pias_pkg::pias_state_t next_st;
  logic setup;
  logic access;
  logic rd_int;
  logic [14:0] ev;
  logic [14:0] next_cause;
  logic [31:0] limit;

  // true when a byte address is one of the four mapped registers
  function automatic logic is_mapped(input logic [7:0] a);
    is_mapped = (a[1:0] == 2'h0) &&
      (a[7:2] == pias_pkg::IDX_MASK[5:0] || a[7:2] == pias_pkg::IDX_INT[5:0] ||
       a[7:2] == pias_pkg::IDX_CFG[5:0] || a[7:2] == pias_pkg::IDX_AUX[5:0]);
  endfunction

  // true when a byte address hits the given register index
  function automatic logic hit(input logic [7:0] a, input logic [7:0] idx);
    hit = (a == {idx[5:0], 2'h0});
  endfunction

  // bus phases and handshake
  assign setup = psel && !penable;
  assign access = psel && penable;
  assign pready = 1'b1;
  assign pslverr = access && !is_mapped(paddr);
  assign rd_int = access && !pwrite && hit(paddr, pias_pkg::IDX_INT);

  // event sources for each cause bit
  always_comb begin
    ev = 15'h0000;
    ev[pias_pkg::BIT_SPD] = st.an_en && (speed != st.pspd);
    ev[pias_pkg::BIT_LINK] = link_up != st.plink;
    ev[pias_pkg::BIT_FDX] = st.an_en && (full_duplex_flag != st.pfdx);
    ev[11] = an_error_evt;
    ev[10] = an_done_evt;
    ev[9] = poe_detect_evt;
    ev[8] = symbol_err_evt;
    ev[7] = fast_fail_evt;
    ev[pias_pkg::BIT_RSVD] = 1'b0;
    ev[5] = ext_int_evt;
    ev[4] = media_change_evt;
    ev[3] = false_carrier_evt;
    ev[pias_pkg::BIT_DSHIFT] = downshift_evt && (&st.adv);
    ev[1] = ms_error_evt;
    ev[pias_pkg::BIT_RXER] = rx_er_evt && !rx_er_carrier_ext;
  end

  // selected power-saving timeout
  always_comb begin
    case ({st.to_msb, st.to_lsb})
      2'b00: limit = TO0_CYC;
      2'b01: limit = TO1_CYC;
      2'b10: limit = TO2_CYC;
      2'b11: limit = TO3_CYC;
      default: limit = TO0_CYC;
    endcase
  end

  // next state of the whole bank
  always_comb begin
    next_st = st;
    // latching continues whether or not the pin is used; a new event beats the read clear.
    // only bits captured at the setup edge are cleared, so a cause latched on that same
    // edge survives the read and is reported by the next one
    next_cause = (st.cause & ~(st.prdata[14:0] & {15{rd_int}})) | ev;
    next_st.cause = next_cause;
    next_st.pend = (st.pend && !(rd_int && st.prdata[15])) ||
      (|(next_cause & st.mask[14:0]));
    next_st.pspd = speed;
    next_st.plink = link_up;
    next_st.pfdx = full_duplex_flag;
    // register writes at the access edge
    if (access && pwrite) begin
      if (hit(paddr, pias_pkg::IDX_MASK)) begin
        next_st.mask = pwdata[15:0];
      end
      if (hit(paddr, pias_pkg::IDX_CFG)) begin
        next_st.an_en = pwdata[pias_pkg::CFG_AN_EN];
        next_st.adv = pwdata[pias_pkg::CFG_ADV_HI:pias_pkg::CFG_ADV_LO];
        next_st.ams_en = pwdata[pias_pkg::CFG_AMS_EN];
        next_st.fx_mode = pwdata[pias_pkg::CFG_FX];
      end
      if (hit(paddr, pias_pkg::IDX_AUX)) begin
        next_st.to_msb = pwdata[pias_pkg::AUX_TO_MSB];
        next_st.ps_en = pwdata[pias_pkg::AUX_PS_EN];
        next_st.to_lsb = pwdata[pias_pkg::AUX_TO_LSB];
      end
    end
    // read data is captured in the setup phase and held through access
    if (setup) begin
      next_st.prdata = 32'h0000_0000;
      if (hit(paddr, pias_pkg::IDX_MASK)) begin
        next_st.prdata[15:0] = st.mask;
      end
      if (hit(paddr, pias_pkg::IDX_INT)) begin
        next_st.prdata[15:0] = {st.pend, st.cause};
      end
      if (hit(paddr, pias_pkg::IDX_CFG)) begin
        next_st.prdata[pias_pkg::CFG_AN_EN] = st.an_en;
        next_st.prdata[pias_pkg::CFG_ADV_HI:pias_pkg::CFG_ADV_LO] = st.adv;
        next_st.prdata[pias_pkg::CFG_AMS_EN] = st.ams_en;
        next_st.prdata[pias_pkg::CFG_FX] = st.fx_mode;
      end
      if (hit(paddr, pias_pkg::IDX_AUX)) begin
        next_st.prdata[15] = st.an_en ? an_complete : link_up;
        next_st.prdata[14] = !st.an_en || (st.ams_en && st.fx_mode);
        next_st.prdata[13] = auto_pair_crossover;
        next_st.prdata[12] = cd_pair_swap;
        next_st.prdata[11:8] = pair_polarity;
        next_st.prdata[pias_pkg::AUX_TO_MSB] = st.to_msb;
        next_st.prdata[pias_pkg::AUX_PS_EN] = st.ps_en;
        next_st.prdata[5] = full_duplex_flag;
        next_st.prdata[4:3] = speed;
        next_st.prdata[pias_pkg::AUX_TO_LSB] = st.to_lsb;
        next_st.prdata[1:0] = media_sel;
      end
    end
    // link-down timer for power saving
    if (!st.ps_en || link_up) begin
      next_st.tmr = 32'h0000_0000;
      next_st.sleep = 1'b0;
    end else if (st.tmr >= limit - 32'h0000_0001) begin
      next_st.sleep = 1'b1;
    end else begin
      next_st.tmr = st.tmr + 32'h0000_0001;
    end
  end

  // state register
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st <= '0;
      st.mask <= pias_pkg::RST_MASK;
      st.an_en <= pias_pkg::RST_AN_EN;
      st.adv <= pias_pkg::RST_ADV;
      st.to_msb <= pias_pkg::RST_TO_MSB;
      st.to_lsb <= pias_pkg::RST_TO_LSB;
      st.ps_en <= pias_pkg::RST_PS_EN;
    end else begin
      st <= next_st;
    end
  end

  // outputs; pin is driven only while mask bit 15 is set
  assign prdata = st.prdata;
  assign phy_interrupt_pin_out = st.pend;
  assign phy_interrupt_pin_oe_n = !st.mask[pias_pkg::BIT_PEND];
  assign link_power_saving_sleep = st.sleep;

  // checks
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  sequence aux_setup_s;
    setup && !pwrite && hit(paddr, pias_pkg::IDX_AUX) && st.an_en;
  endsequence

  sequence aux_access_s;
    access && !pwrite;
  endsequence

  read_clears_a: assert property (
    (rd_int && ev == 15'h0000) |=>
      ((st.cause & $past(st.prdata[14:0])) == 15'h0000 &&
       (!st.pend || (|(st.cause & st.mask[14:0])))))
    else $error("status not cleared by read");
  set_wins_a: assert property (
    (rd_int && ev[pias_pkg::BIT_LINK]) |=> st.cause[pias_pkg::BIT_LINK])
    else $error("event lost during read clear");
  spd_gate_a: assert property (
    $rose(st.cause[pias_pkg::BIT_SPD]) |-> $past(st.an_en))
    else $error("speed change latched with autoneg off");
  dshift_gate_a: assert property (
    $rose(st.cause[pias_pkg::BIT_DSHIFT]) |-> $past(st.adv) == 4'hF)
    else $error("downshift latched without full advert");
  rxer_gate_a: assert property (
    (rx_er_carrier_ext && !st.cause[0]) |=> !st.cause[0])
    else $error("rx error latched during carrier extension");
  rsvd_zero_a: assert property (
    !st.cause[pias_pkg::BIT_RSVD])
    else $error("reserved status bit set");
  summary_set_a: assert property (
    (|(ev & st.mask[14:0])) |=> st.pend ##1 (st.pend || $past(rd_int)))
    else $error("summary not set by masked cause");
  pin_follow_a: assert property (
    (st.mask[15] && $rose(st.pend)) |->
      (phy_interrupt_pin_out && !phy_interrupt_pin_oe_n))
    else $error("interrupt pin not following summary");
  aux_ancpl_a: assert property (
    (aux_setup_s ##1 aux_access_s) |-> prdata[15] == $past(an_complete))
    else $error("aux bit 15 not autoneg complete");
  sleep_link_a: assert property (link_up |=> !link_power_saving_sleep)
    else $error("sleep asserted with link up");

endmodule

/* verilog/pias_pkg.sv */
/*
  package for the phy interrupt and auxiliary status bank: register indices,
  field positions, reset values, timeout figures and the state record.
  assumes a 20 MHz apb clock; byte address of a register is four times its index.
*/
package pias_pkg;
  // register indices; byte address is index * 4
  localparam logic [7:0] IDX_MASK = 8'h19;
  localparam logic [7:0] IDX_INT = 8'h1A;
  localparam logic [7:0] IDX_CFG = 8'h1B;
  localparam logic [7:0] IDX_AUX = 8'h1C;
  // status bit positions
  localparam int BIT_PEND = 15;
  localparam int BIT_SPD = 14;
  localparam int BIT_LINK = 13;
  localparam int BIT_FDX = 12;
  localparam int BIT_RSVD = 6;
  localparam int BIT_DSHIFT = 2;
  localparam int BIT_RXER = 0;
  // configuration register fields
  localparam int CFG_AN_EN = 12;
  localparam int CFG_ADV_HI = 8;
  localparam int CFG_ADV_LO = 5;
  localparam int CFG_AMS_EN = 1;
  localparam int CFG_FX = 0;
  // auxiliary writable fields
  localparam int AUX_TO_MSB = 7;
  localparam int AUX_PS_EN = 6;
  localparam int AUX_TO_LSB = 2;
  // values after reset
  localparam logic [15:0] RST_MASK = 16'h0000;
  localparam logic RST_AN_EN = 1'b1;
  localparam logic [3:0] RST_ADV = 4'hF;
  localparam logic RST_TO_MSB = 1'b0;
  localparam logic RST_TO_LSB = 1'b1;
  localparam logic RST_PS_EN = 1'b0;
  // power-saving link timeouts in ms and the clock rate in kHz
  localparam int CLK_KHZ = 20000;
  localparam int TO0_MS = 2300;
  localparam int TO1_MS = 3300;
  localparam int TO2_MS = 4300;
  localparam int TO3_MS = 5300;
  localparam int TO0_CYC = TO0_MS * CLK_KHZ;
  localparam int TO1_CYC = TO1_MS * CLK_KHZ;
  localparam int TO2_CYC = TO2_MS * CLK_KHZ;
  localparam int TO3_CYC = TO3_MS * CLK_KHZ;

  // complete state of the bank
  typedef struct packed {
    logic [14:0] cause;
    logic pend;
    logic [15:0] mask;
    logic an_en;
    logic [3:0] adv;
    logic ams_en;
    logic fx_mode;
    logic to_msb;
    logic ps_en;
    logic to_lsb;
    logic [1:0] pspd;
    logic plink;
    logic pfdx;
    logic [31:0] prdata;
    logic [31:0] tmr;
    logic sleep;
  } pias_state_t;
endpackage

/* tb/pias_bank_tb.sv */
/*
  self-checking bench for the phy interrupt and auxiliary status bank.
  assumes the zero wait state apb slave and the short timeout parameters set below.
*/
`timescale 1ns/10ps
module pias_bank_tb;
  localparam logic [7:0] A_MASK = 8'h64;
  localparam logic [7:0] A_INT = 8'h68;
  localparam logic [7:0] A_CFG = 8'h6C;
  localparam logic [7:0] A_AUX = 8'h70;
  localparam int LIM [4] = '{20, 30, 40, 50};
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata, rdv;
  logic link_up, full_duplex_flag, an_complete, rx_er_carrier_ext, auto_pair_crossover;
  logic cd_pair_swap, pin_out, pin_oe_n, sleep, errv;
  logic [1:0] speed, media_sel;
  logic [3:0] pair_polarity;
  logic [11:0] ev;
  int err_count, compares;

  pias_bank #(.TO0_CYC(20), .TO1_CYC(30), .TO2_CYC(40), .TO3_CYC(50)) pias_bank_i (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .link_up(link_up), .speed(speed), .full_duplex_flag(full_duplex_flag),
    .an_complete(an_complete), .an_error_evt(ev[11]), .an_done_evt(ev[10]),
    .poe_detect_evt(ev[9]), .symbol_err_evt(ev[8]), .fast_fail_evt(ev[7]),
    .ext_int_evt(ev[5]), .media_change_evt(ev[4]), .false_carrier_evt(ev[3]),
    .downshift_evt(ev[2]), .ms_error_evt(ev[1]), .rx_er_evt(ev[0]),
    .rx_er_carrier_ext(rx_er_carrier_ext), .auto_pair_crossover(auto_pair_crossover),
    .cd_pair_swap(cd_pair_swap), .pair_polarity(pair_polarity), .media_sel(media_sel),
    .phy_interrupt_pin_out(pin_out), .phy_interrupt_pin_oe_n(pin_oe_n),
    .link_power_saving_sleep(sleep));

  // 50 ns clock
  initial begin
    pclk = 1'b0;
    forever #25 pclk = ~pclk;
  end

  // ends the run with the verdict
  task automatic complete_run();
    $display("compares %0d err_count %0d", compares, err_count);
    if (err_count == 0 && compares > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask

  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    compares++;
    if (seen !== exp) begin
      err_count++;
      $display("CHECK FAILED %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  // one apb transfer: setup, then access until pready
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] wd);
    int n;
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= wd;
    @(posedge pclk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 50);
    if (pready !== 1'b1) begin
      err_count++;
      $display("CHECK FAILED pready expected 1 seen %b", pready);
    end
    rdv = prdata;
    errv = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic rd(input logic [7:0] a, input logic [15:0] e, input string nm);
    apb(1'b0, a, 32'h0);
    chk(nm, rdv, {16'h0000, e});
  endtask

  task automatic pulse(input int i);
    @(posedge pclk);
    ev[i] <= 1'b1;
    @(posedge pclk);
    ev[i] <= 1'b0;
    @(negedge pclk);
  endtask

  // watchdog against a hung handshake
  initial begin
    repeat (20000) @(posedge pclk);
    err_count++;
    complete_run();
  end

  // main sequence
  initial begin
    {presetn, psel, penable, pwrite, paddr, pwdata, link_up, speed} = '0;
    {full_duplex_flag, an_complete, rx_er_carrier_ext, auto_pair_crossover} = '0;
    {cd_pair_swap, pair_polarity, media_sel, ev} = '0;
    err_count = 0;
    compares = 0;
    repeat (6) @(posedge pclk);
    presetn <= 1'b1;
    chk("pin_idle", {30'h0, pin_oe_n, pin_out}, 32'h2);
    rd(A_AUX, 16'h0004, "aux_reset");
    rd(A_INT, 16'h0000, "int_reset");
    // each of causes 0 to 11 except reserved bit 6, unmasked then masked
    for (int m = 0; m < 2; m++) begin
      apb(1'b1, A_MASK, m ? 32'hFFFF : 32'h0);
      @(negedge pclk);
      chk("pin_oe_n", {31'h0, pin_oe_n}, 32'(1 - m));
      for (int i = 0; i < 12; i++) begin
        if (i != 6) begin
          pulse(i);
          chk("pin", {31'h0, pin_out}, 32'(m));
          rd(A_INT, 16'(m << 15) | 16'(1 << i), "cause");
          rd(A_INT, 16'h0000, "cleared");
          chk("pin_clr", {31'h0, pin_out}, 32'h0);
        end
      end
    end
    rx_er_carrier_ext <= 1'b1;
    pulse(0);
    rd(A_INT, 16'h0000, "carrier_ext");
    rx_er_carrier_ext <= 1'b0;
    apb(1'b1, A_CFG, 32'h1000);
    pulse(2);
    rd(A_INT, 16'h0000, "no_advert");
    apb(1'b1, A_CFG, 32'h11E0);
    link_up <= 1'b1;
    rd(A_INT, 16'hA000, "link_chg");
    speed <= 2'b10;
    rd(A_INT, 16'hC000, "speed_chg");
    full_duplex_flag <= 1'b1;
    rd(A_INT, 16'h9000, "fdx_chg");
    apb(1'b1, A_CFG, 32'h01E0);
    speed <= 2'b01;
    full_duplex_flag <= 1'b0;
    rd(A_INT, 16'h0000, "an_off_chg");
    {auto_pair_crossover, cd_pair_swap, pair_polarity, media_sel} <= 8'hEA;
    full_duplex_flag <= 1'b1;
    rd(A_AUX, 16'hFA2E, "aux_an_off");
    apb(1'b1, A_CFG, 32'h11E0);
    rd(A_AUX, 16'h3A2E, "aux_an_on");
    an_complete <= 1'b1;
    rd(A_AUX, 16'hBA2E, "aux_an_done");
    apb(1'b1, A_CFG, 32'h11E3);
    rd(A_AUX, 16'hFA2E, "aux_fiber");
    apb(1'b1, A_AUX, 32'hFFFF);
    rd(A_AUX, 16'hFAEE, "aux_rw_set");
    apb(1'b1, A_AUX, 32'h0);
    rd(A_AUX, 16'hFA2A, "aux_rw_clr");
    apb(1'b0, 8'h00, 32'h0);
    chk("unmapped", {errv, rdv[30:0]}, 32'h80000000);
    // each timeout code against its link-down span
    for (int c = 0; c < 4; c++) begin
      link_up <= 1'b1;
      apb(1'b1, A_AUX, 32'h40 | 32'((c & 2) << 6) | 32'((c & 1) << 2));
      @(posedge pclk);
      link_up <= 1'b0;
      repeat (LIM[c] - 3) @(posedge pclk);
      @(negedge pclk);
      chk("sleep_early", {31'h0, sleep}, 32'h0);
      repeat (5) @(posedge pclk);
      @(negedge pclk);
      chk("sleep_due", {31'h0, sleep}, 32'h1);
    end
    complete_run();
  end
endmodule
